/* hw/fit_pins.sv */
/*
 Flag, external interrupt request and timer expiry pin logic.
 Assumes software controls arrive as plain core-clock ports, the
 interrupt controller returns one-cycle service pulses, and timer 0
 gives a one-cycle expiry pulse. Request pins are active low.
*/
`timescale 1ns/100ps
`default_nettype none
module fit_pins
   import fit_pkg::*;
#(
   parameter int NFLAG = fit_pkg::FLAG_COUNT,
   parameter int NIRQ  = fit_pkg::IRQ_COUNT
) (
   input  wire logic            sys_clk,        // Core clock 200 MHz
   input  wire logic            srst,           // Sync reset, high
   input  wire logic [NFLAG-1:0] flagDirIn,     // 1 = output per flag
   input  wire logic [NFLAG-1:0] flagOutData,   // Flag output values
   input  wire logic            flagCfgWr,      // Load dir and data
   input  wire logic [NFLAG-1:0] programFlagPinsIn, // Flag pin level
   output logic      [NFLAG-1:0] programFlagPinsOut,// Flag pin drive
   output logic      [NFLAG-1:0] programFlagPinsOe, // Flag drive enable
   output logic      [NFLAG-1:0] flagCondition, // Sequencer conditions
   input  wire logic [NIRQ-1:0] irqModeIn,      // 1 = edge sensing
   input  wire logic [NIRQ-1:0] irqEnableIn,    // Enable per request
   input  wire logic            irqCfgWr,       // Load mode and enable
   input  wire logic [NIRQ-1:0] externalInterruptRequestsN, // Pins, low
   input  wire logic [NIRQ-1:0] irqServiced,    // Service pulses
   output logic      [NIRQ-1:0] irqRaise,       // To controller
   output logic      [NIRQ-1:0] irqEnableState, // Enable readback
   input  wire logic            timer0Expired,  // Timer 0 expiry pulse
   input  wire logic            timerExpiryOutputIn, // Pin level
   output logic                 timerExpiryOutput,   // Pin drive
   output logic                 timerExpiryOutputOe, // Pin enable
   output logic                 irqBootStrap    // Strap sampled at reset
);
   localparam int NSYNC = NFLAG + NIRQ;
   localparam int PCW   = $clog2(TMR_PULSE_CYCLES + 1);

   logic [NFLAG-1:0] flagDir_r, flagDir_nxt;
   logic [NFLAG-1:0] flagOut_r, flagOut_nxt;
   logic [NIRQ-1:0]  irqMode_r, irqMode_nxt;
   logic [NIRQ-1:0]  irqEn_r, irqEn_nxt;
   logic [NIRQ-1:0]  irqPend_r, irqPend_nxt;
   logic [NIRQ-1:0]  irqPrev_r, irqPrev_nxt;
   logic             strap_r, strap_nxt;
   logic             inReset_r, inReset_nxt;
   logic [PCW-1:0]   pulseCnt_r, pulseCnt_nxt;
   logic             tmrOut_r, tmrOut_nxt;
   logic [NFLAG-1:0] flagSync;
   logic [NIRQ-1:0]  irqActive;
   logic             strapSync;

   fit_sync_if #(.WIDTH(NSYNC)) syncBus ();
   fit_sync_if #(.WIDTH(1))     strapBus ();

   assign syncBus.rawLevel = {externalInterruptRequestsN,
                              programFlagPinsIn};
   fit_sync #(
      .WIDTH  (NSYNC),
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .port    (syncBus.sync)
   );
   assign flagSync  = syncBus.syncLevel[NFLAG-1:0];
   assign irqActive = ~syncBus.syncLevel[NSYNC-1:NFLAG];

   // Strap chain is never reset: a reset chain would hold its
   // idle level and hide the strap for the whole reset period.
   // Its level is only used during reset and the first cycle after release.
   // strap synchroniser
   assign strapBus.rawLevel = timerExpiryOutputIn;
   fit_sync #(
      .WIDTH  (1),
      .STAGES (SYNC_STAGES)
   ) u_strapSync (
      .sys_clk (sys_clk),
      .srst    (1'h0),
      .port    (strapBus.sync)
   );
   assign strapSync = strapBus.syncLevel[0];

   // Flag direction and data registers
   always_comb begin
      flagDir_nxt = flagDir_r;
      flagOut_nxt = flagOut_r;
      if (flagCfgWr) begin
         flagDir_nxt = flagDirIn;
         flagOut_nxt = flagOutData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flagDir_r <= FLAG_DIR_RST;
         flagOut_r <= FLAG_OUT_RST;
      end else begin
         flagDir_r <= flagDir_nxt;
         flagOut_r <= flagOut_nxt;
      end
   end

   assign programFlagPinsOut = flagOut_r;
   assign programFlagPinsOe  = flagDir_r;
   assign flagCondition      = flagSync;

   // Strap capture while reset is held, then boot enable on release
   // Boot enable uses the strap held from the last reset cycle
   always_comb begin
      inReset_nxt = srst;
      strap_nxt   = strap_r;
      irqMode_nxt = irqMode_r;
      irqEn_nxt   = irqEn_r;
      if (inReset_r) begin
         strap_nxt = strapSync;
      end
      if (inReset_r && !srst && strap_r) begin
         irqEn_nxt = {NIRQ{1'b1}};
      end else if (irqCfgWr) begin
         irqMode_nxt = irqModeIn;
         irqEn_nxt   = irqEnableIn;
      end
   end

   always_ff @(posedge sys_clk) begin
      inReset_r <= inReset_nxt;
      strap_r   <= strap_nxt;
      if (srst) begin
         irqMode_r <= IRQ_MODE_RST;
         irqEn_r   <= IRQ_EN_RST;
      end else begin
         irqMode_r <= irqMode_nxt;
         irqEn_r   <= irqEn_nxt;
      end
   end

   // Edge detect and pending latch
   // Disable or level mode drops any pending edge
   always_comb begin
      irqPrev_nxt = irqActive;
      irqPend_nxt = irqPend_r;
      for (int i = 0; i < NIRQ; i++) begin
         if (irqServiced[i]) begin
            irqPend_nxt[i] = 1'b0;
         end
         if (irqMode_r[i] && irqEn_r[i] && irqActive[i] && !irqPrev_r[i])
         begin
            irqPend_nxt[i] = 1'b1;
         end
         if (!irqMode_r[i] || !irqEn_r[i]) begin
            irqPend_nxt[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irqPend_r <= IRQ_PEND_RST;
         irqPrev_r <= IRQ_PEND_RST;
      end else begin
         irqPend_r <= irqPend_nxt;
         irqPrev_r <= irqPrev_nxt;
      end
   end

   assign irqRaise = irqEn_r & ((irqMode_r & irqPend_r) |
                                (~irqMode_r & irqActive));
   assign irqEnableState = irqEn_r;

   // Timer expiry pulse stretcher
   // A new expiry restarts the count, so expiries closer than
   // the pulse width merge into one longer pulse
   always_comb begin
      pulseCnt_nxt = pulseCnt_r;
      tmrOut_nxt   = 1'b0;
      if (timer0Expired) begin
         pulseCnt_nxt = PCW'(TMR_PULSE_CYCLES);
      end else if (pulseCnt_r != '0) begin
         pulseCnt_nxt = pulseCnt_r - PCW'(1);
      end
      if (timer0Expired || pulseCnt_r > PCW'(1)) begin
         tmrOut_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pulseCnt_r <= '0;
         tmrOut_r   <= 1'b0;
      end else begin
         pulseCnt_r <= pulseCnt_nxt;
         tmrOut_r   <= tmrOut_nxt;
      end
   end

   assign timerExpiryOutput   = tmrOut_r;
   assign timerExpiryOutputOe = ~inReset_r & ~srst;
   assign irqBootStrap        = strap_r;
endmodule
`default_nettype wire

/* hw/fit_pkg.sv */
/*
 Package for the flag, interrupt request and timer pin block.
 Assumes a single core clock and a synchronous active-high reset.
*/
package fit_pkg;
   localparam int FLAG_COUNT  = 4;                 // General-purpose flags
   localparam int IRQ_COUNT   = 4;                 // Interrupt request inputs
   localparam int SYNC_STAGES = 2;                 // Synchroniser depth
   localparam logic [3:0] FLAG_DIR_RST  = 4'h0;    // All inputs at reset
   localparam logic [3:0] FLAG_OUT_RST  = 4'h0;    // Output data at reset
   localparam logic [3:0] IRQ_MODE_RST  = 4'h0;    // Level sensing at reset
   localparam logic [3:0] IRQ_EN_RST    = 4'h0;    // Disabled at reset
   localparam logic [3:0] IRQ_PEND_RST  = 4'h0;    // Nothing pending
   localparam logic       SYNC_RST      = 1'h1;    // Pins idle high (pull-up)
   localparam logic       STRAP_RST     = 1'h0;    // Strap capture default
   // Timer expiry pulse width
   localparam int TMR_PULSE_NS     = 5;
   localparam int CLK_PERIOD_NS    = 5;
   localparam int TMR_PULSE_CYCLES =
      (TMR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* hw/fit_sync_if.sv */
/*
 Interface carrying raw pin levels into the synchroniser and the
 synchronised levels back out. Assumes both ends share sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface fit_sync_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] rawLevel;   // Asynchronous levels
   logic [WIDTH-1:0] syncLevel;  // Levels in core domain
   modport core (output rawLevel, input syncLevel);
   modport sync (input rawLevel, output syncLevel);
endinterface
`default_nettype wire

/* hw/fit_sync.sv */
/*
 Multi-stage synchroniser bank for asynchronous pin inputs.
 Assumes the inputs may change at any time relative to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module fit_sync #(
   parameter int WIDTH  = 8,
   parameter int STAGES = fit_pkg::SYNC_STAGES
) (
   input  wire logic sys_clk,   // Core clock
   input  wire logic srst,      // Synchronous reset
   fit_sync_if.sync  port       // Raw in, synchronised out
);
   import fit_pkg::*;
   logic [WIDTH-1:0] stage_r   [STAGES];
   logic [WIDTH-1:0] stage_nxt [STAGES];

   // Shift chain; first stage read only by the second
   always_comb begin
      stage_nxt[0] = port.rawLevel;
      for (int i = 1; i < STAGES; i++) begin
         stage_nxt[i] = stage_r[i-1];
      end
   end

   // Register the chain
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < STAGES; i++) begin
         if (srst) begin
            stage_r[i] <= {WIDTH{SYNC_RST}};
         end else begin
            stage_r[i] <= stage_nxt[i];
         end
      end
   end

   assign port.syncLevel = stage_r[STAGES-1];
endmodule
`default_nettype wire

/* verification/fit_board.sv */
/* Board model for the flag, request and expiry pins.
 Assumes pull-ups on flags and requests; strap level set by bench. */
`timescale 1ns/100ps
`default_nettype none
module fit_board (
   input  wire logic [3:0] flagOut,  // Design drive
   input  wire logic [3:0] flagOe,   // Design enable
   input  wire logic [3:0] extVal,   // Board drive
   input  wire logic [3:0] extEn,    // Board enable
   input  wire logic       tmrOut,   // Design expiry
   input  wire logic       tmrOe,    // Design enable
   input  wire logic       strapLvl, // Strap level
   input  wire logic [3:0] irqPull,  // Lines pulled low
   output logic      [3:0] flagPin,  // Resolved flags
   output logic      [3:0] irqPinN,  // Request lines
   output logic            tmrPin    // Resolved expiry
);
   // Pull-ups where nobody drives; strap shown while undriven
   always_comb begin
      flagPin = (flagOe & flagOut) | (~flagOe & (~extEn | extVal));
      irqPinN = ~irqPull;
      tmrPin  = tmrOe ? tmrOut : strapLvl;
   end
endmodule
`default_nettype wire

/* verification/fit_pins_asserts.sv */
/* Port checker for fit_pins.
 Assumes a bind from the bench top file. */
`timescale 1ns/100ps
`default_nettype none
module fit_pins_asserts (
   input wire logic       sys_clk,             // Clock
   input wire logic       srst,                // Reset
   input wire logic [3:0] flagDirIn,           // Direction
   input wire logic [3:0] flagOutData,         // Data
   input wire logic       flagCfgWr,           // Flag load
   input wire logic [3:0] programFlagPinsIn,   // Pin level
   input wire logic [3:0] programFlagPinsOut,  // Pin drive
   input wire logic [3:0] programFlagPinsOe,   // Pin enable
   input wire logic [3:0] flagCondition,       // Conditions
   input wire logic [3:0] irqRaise,            // Requests out
   input wire logic [3:0] irqEnableState,      // Enables
   input wire logic       timer0Expired,       // Expiry in
   input wire logic       timerExpiryOutput,   // Expiry out
   input wire logic       timerExpiryOutputOe, // Expiry enable
   input wire logic       irqBootStrap         // Strap
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Steps used below
   sequence sRel; $past(srst); endsequence
   sequence sFlat; $stable(programFlagPinsIn) [*4]; endsequence
   sequence sTmr; timer0Expired ##1 timerExpiryOutput; endsequence
   AST_OE_RST: assert property (sRel |-> programFlagPinsOe == 4'h0)
      else $error("flag drivers on after reset");
   AST_DIR: assert property (
      flagCfgWr |=> programFlagPinsOe == $past(flagDirIn))
      else $error("flag direction not loaded");
   AST_DAT: assert property (
      flagCfgWr |=> programFlagPinsOut == $past(flagOutData))
      else $error("flag data not loaded");
   AST_COND: assert property (
      sFlat |-> flagCondition == programFlagPinsIn)
      else $error("condition differs from pin");
   AST_EN_RST: assert property (sRel |-> irqEnableState == 4'h0)
      else $error("requests enabled in reset");
   AST_BOOT: assert property (
      sRel ##0 irqBootStrap |=> irqEnableState == 4'hF)
      else $error("boot strap did not enable");
   AST_MASK: assert property ((irqRaise & ~irqEnableState) == 4'h0)
      else $error("disabled request raised");
   AST_TMR: assert property (timer0Expired |-> sTmr)
      else $error("expiry pulse missing");
   AST_TMR_IDLE: assert property (
      timerExpiryOutput |-> $past(timer0Expired))
      else $error("expiry output without expiry");
   AST_TMR_OE: assert property (
      sRel |-> !timerExpiryOutputOe ##2 timerExpiryOutputOe)
      else $error("expiry pin enable wrong");
   AST_STRAP: assert property (!$past(srst) |-> $stable(irqBootStrap))
      else $error("strap changed after reset");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
/* Self-checking bench for fit_pins with a board model.
 Assumes fit_pkg, fit_board and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic sys_clk = 0, srst = 1, flagCfgWr = 0, irqCfgWr = 0;
   logic tmrExp = 0, strap = 1, started = 0;
   logic [3:0] dir = 0, dat = 0, mode = 0, en = 0, svc = 0;
   logic [3:0] ext = 0, extEn = 0, pull = 0, xE, xO, xR, xC;
   logic xB, xT;
   wire logic [3:0] fPin, fOut, fOe, cond, irqN, raise, enS;
   wire logic tPin, tOut, tOe, boot;
   wire logic [17:0] obs = {boot, enS, fOe, tOut, raise, cond};
   logic [17:0] q[$], prev = 'x, last = 'x;
   int error_cnt = 0, checks_done = 0;
   integer seed = 32'h29ED6D91;
   fit_pins i_fit_pins (.sys_clk, .srst, .flagDirIn(dir), .flagOutData(dat),
      .flagCfgWr, .programFlagPinsIn(fPin), .programFlagPinsOut(fOut),
      .programFlagPinsOe(fOe), .flagCondition(cond), .irqModeIn(mode),
      .irqEnableIn(en), .irqCfgWr, .externalInterruptRequestsN(irqN),
      .irqServiced(svc), .irqRaise(raise), .irqEnableState(enS),
      .timer0Expired(tmrExp), .timerExpiryOutputIn(tPin),
      .timerExpiryOutput(tOut), .timerExpiryOutputOe(tOe),
      .irqBootStrap(boot));
   fit_board i_fit_board (.flagOut(fOut), .flagOe(fOe), .extVal(ext),
      .extEn, .tmrOut(tOut), .tmrOe(tOe), .strapLvl(strap),
      .irqPull(pull), .flagPin(fPin), .irqPinN(irqN), .tmrPin(tPin));
   // Clock 200 MHz
   always #2.5 sys_clk = ~sys_clk;
   task automatic results();
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Note the next expected output state
   task automatic upd();
      logic [17:0] note;
      note = {xB, xE, xO, xT, xR, xC};
      if (note !== prev) begin
         q.push_back(note);
      end
      prev = note;
   endtask
   task automatic settle();
      xC = (xO & dat) | (~xO & (~extEn | ext));
      upd();
      tick(6);
   endtask
   // Compare each output change with the oldest note
   initial forever begin
      @(negedge sys_clk);
      if (started && obs !== last) begin
         last = obs;
         checks_done++;
         if (q.size() == 0 || q[0] !== obs) begin
            error_cnt++;
            $display("[ERR] outputs exp %h seen %h",
                     q.size() ? q[0] : 18'h0, obs);
         end
         if (q.size() != 0) void'(q.pop_front());
      end
   end
   initial begin
      #20000;
      error_cnt++;
      results();
   end
   initial begin
      {xB, xE, xO, xT, xR, xC} = {1'h1, 4'hF, 4'h0, 1'h0, 4'h0, 4'hF};
      upd();
      tick(20);
      srst = 0;
      tick(6);
      started = 1;
      repeat (6) begin
         extEn = 0;
         settle();
         dir = 4'($random(seed));
         dat = 4'($random(seed));
         flagCfgWr = 1;
         tick(1);
         flagCfgWr = 0;
         xO = dir;
         upd();
         settle();
         ext = 4'($random(seed));
         extEn = ~dir;
         settle();
      end
      // edge on lines 1 and 3, line 2 off
      mode = 4'hA;
      en = 4'hB;
      irqCfgWr = 1;
      tick(1);
      irqCfgWr = 0;
      xE = 4'hB;
      upd();
      tick(6);
      pull = 4'h1; xR = 4'h1; upd(); tick(6);
      pull = 4'h0; xR = 4'h0; upd(); tick(6);
      pull = 4'h2; xR = 4'h2; upd(); tick(6);
      pull = 4'h0; tick(6);
      svc = 4'h2; tick(1); svc = 0; xR = 0; upd(); tick(6);
      pull = 4'h4; tick(6); pull = 0; tick(6);
      xT = 1; upd(); xT = 0; upd();
      tmrExp = 1; tick(2); tmrExp = 0; tick(6);
      started = 0; strap = 0; extEn = 0; srst = 1;
      tick(20);
      srst = 0;
      tick(6);
      {xB, xE, xO, xC} = {1'h0, 4'h0, 4'h0, 4'hF};
      prev = 'x;
      upd();
      last = 'x;
      started = 1;
      pull = 4'hF; tick(6); pull = 0; tick(6);
      if (q.size() != 0) begin
         error_cnt++;
         $display("[ERR] notes left exp 0 seen %0d", q.size());
      end
      results();
   end
endmodule
bind fit_pins fit_pins_asserts i_fit_pins_asserts (.*);
`default_nettype wire
